// ==== rtl/vfdsc_top.sv ====
// Fluorescent display scan controller: registers, DMA fetch, scan timing
// Assumes register port, DMA memory and port latches on CLK_I
//
// Functional notes
// - DMA fetches segment data, drives strobes autonomously
// - Nine to 24 segments, nine to 16 digits
// - Unscanned pins output static or port data
// - Digit pulse width has eight levels
// - Key scan slot raises an interrupt request
// - Key slot segments show the three key buffers
// - Period equals display cycle times N plus two
// - Reset clears display mode register, display stopped
// - Low three mode bits give nine to 16 segments
// - Dynamic upper pins add eight more segments
// - Mode bit three enables or stops scanning
// - Digit select N scans N plus one digits
// - Reset loads digit select with eight
// - Display data lives at 1A0H to 1FFH
// - Cycle length select gives 1024 or 2048 clocks
// - Cut width is 1/16 to 14/16 of cycle
// - Key scan flag reads one only in key slot
`include "vfdsc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module vfdsc_top (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    // Register port
    input  wire logic [11:0] REG_ADDR_I,
    input  wire logic [3:0]  REG_WDATA_I,
    input  wire logic        REG_WE_I,
    input  wire logic        REG_RE_I,
    output logic      [3:0]  REG_RDATA_O,
    // DMA read port
    output logic             DMA_REQ_O,
    output logic      [8:0]  DMA_ADDR_O,
    input  wire logic        DMA_GNT_I,
    input  wire logic [7:0]  DMA_DATA_I,
    // Port latches for unscanned pins
    input  wire logic [23:0] PORT_SEG_I,
    input  wire logic [15:0] PORT_DIG_I,
    // Display and interrupt
    output logic      [23:0] SEG_O,
    output logic      [15:0] DIG_O,
    output logic             KEY_SCAN_IRQ_O
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Cut width in sixteenths for a dimmer code
    function automatic logic [3:0] cut_of(input logic [2:0] c);
        return (c == 3'h0) ? 4'h1 : {c, 1'b0};
    endfunction : cut_of

    // Last slot index of a period, the key slot
    function automatic logic [4:0] last_of(input logic [3:0] n);
        return {1'b0, n} + 5'h01;
    endfunction : last_of

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [3:0] mode_q, next_mode;    // display_mode_ctrl
    logic [3:0] dim_q, next_dim;      // dimmer_select
    logic [3:0] digit_count_select_q, next_digit_count_select;    // digit_count_select
    logic [1:0] upper_segment_static_sel_q, next_upper_segment_static_sel;  // upper_segment_static_sel
    logic [3:0] next_rdata;
    logic       ksf_q, next_ksf;      // key_scan_slot_flag

    // Write decode and read mux
    always_comb begin
        next_mode  = mode_q;
        next_dim   = dim_q;
        next_digit_count_select  = digit_count_select_q;
        next_upper_segment_static_sel = upper_segment_static_sel_q;
        next_rdata = 4'h0;            // Unmapped reads zero
        if (REG_WE_I) begin
            case (REG_ADDR_I)
                `VFD_ADDR_MODE:  next_mode  = REG_WDATA_I;
                `VFD_ADDR_DIM:   next_dim   = REG_WDATA_I;
                `VFD_ADDR_DIGIT: next_digit_count_select  = REG_WDATA_I;
                `VFD_ADDR_UPPER_SEGMENT_STATIC_SEL: next_upper_segment_static_sel = REG_WDATA_I[1:0];
                default: ;            // Ignored
            endcase
        end
        if (REG_RE_I) begin
            case (REG_ADDR_I)
                `VFD_ADDR_MODE:  next_rdata = mode_q;
                `VFD_ADDR_DIM:   next_rdata = dim_q;
                `VFD_ADDR_DIGIT: next_rdata = {ksf_q, digit_count_select_q[2:0]};
                `VFD_ADDR_UPPER_SEGMENT_STATIC_SEL: next_rdata = {2'h0, upper_segment_static_sel_q};
                default:         next_rdata = 4'h0;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            mode_q      <= `VFD_MODE_RST;
            dim_q       <= `VFD_DIM_RST;
            digit_count_select_q      <= `VFD_DIGIT_RST;
            upper_segment_static_sel_q     <= `VFD_UPPER_SEGMENT_STATIC_SEL_RST;
            REG_RDATA_O <= 4'h0;
        end else begin
            mode_q      <= next_mode;
            dim_q       <= next_dim;
            digit_count_select_q      <= next_digit_count_select;
            upper_segment_static_sel_q     <= next_upper_segment_static_sel;
            REG_RDATA_O <= next_rdata;
        end
    end

    // Live configuration; values 0..7 for N are forced to 8..15
    vfdsc_pkg::vfdsc_cfg_s live_cfg;
    always_comb begin
        live_cfg.segk      = mode_q[2:0];
        live_cfg.n         = {1'b1, digit_count_select_q[2:0]};
        live_cfg.cyc_long  = dim_q[0];
        live_cfg.cut       = dim_q[3:1];
        live_cfg.up_static = upper_segment_static_sel_q[0];
    end

    // ----------------------------------------------------------------
    // Scan timing
    // ----------------------------------------------------------------
    vfdsc_pkg::vfdsc_cfg_s cfg_q, next_cfg;  // Period configuration
    logic        running_q, next_running;   // Scan active
    logic [10:0] cyc_q, next_cyc;           // Clock within cycle
    logic [4:0]  slot_q, next_slot;         // Cycle within period
    logic        loaded_q, next_loaded;     // Word taken this cycle
    logic [23:0] word_q, next_word;         // Current segment word
    logic        next_irq;
    logic        cyc_end, key_slot, digit_on, period_end;
    logic        start, stop, restart, pop;
    logic [3:0]  pos16;
    logic        fifo_valid;
    vfdsc_pkg::vfdsc_word_s fifo_word;

    // Slot sequencing and word pickup
    always_comb begin
        cyc_end    = cyc_q == (cfg_q.cyc_long ? `VFD_CYC_LONG : `VFD_CYC_SHORT);
        key_slot   = slot_q == last_of(cfg_q.n);
        pos16      = cfg_q.cyc_long ? cyc_q[10:7] : cyc_q[9:6];
        digit_on   = pos16 >= cut_of(cfg_q.cut);
        period_end = running_q & cyc_end & key_slot;
        start      = mode_q[`VFD_EN_BIT] & (~running_q | period_end);
        stop       = ~mode_q[`VFD_EN_BIT] & running_q;
        restart    = start | stop;
        pop        = running_q & ~restart & ~loaded_q & fifo_valid
                   & (key_slot | digit_on);
        next_running = start ? 1'b1 : (stop ? 1'b0 : running_q);
        next_cfg     = start ? live_cfg : cfg_q;
        next_cyc     = cyc_q;
        next_slot    = slot_q;
        next_loaded  = loaded_q;
        next_word    = word_q;
        if (restart) begin                  // New period or stop
            next_cyc    = 11'h000;
            next_slot   = 5'h00;
            next_loaded = 1'b0;
            next_word   = 24'h000000;
        end else if (running_q) begin
            next_cyc = cyc_end ? 11'h000 : 11'(cyc_q + 11'h001);
            if (cyc_end) begin              // Next digit cycle
                next_slot   = 5'(slot_q + 5'h01);
                next_loaded = 1'b0;
            end else if (pop) begin         // Take word after cut, or at once in key slot
                next_loaded = 1'b1;
                next_word   = fifo_word;
            end
        end
        next_ksf = next_running & (next_slot == last_of(next_cfg.n));
        next_irq = next_ksf & ~ksf_q;
    end

    // Timing registers
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            cfg_q          <= '0;
            running_q      <= 1'b0;
            cyc_q          <= 11'h000;
            slot_q         <= 5'h00;
            loaded_q       <= 1'b0;
            word_q         <= 24'h000000;
            ksf_q          <= 1'b0;
            KEY_SCAN_IRQ_O <= 1'b0;
        end else begin
            cfg_q          <= next_cfg;
            running_q      <= next_running;
            cyc_q          <= next_cyc;
            slot_q         <= next_slot;
            loaded_q       <= next_loaded;
            word_q         <= next_word;
            ksf_q          <= next_ksf;
            KEY_SCAN_IRQ_O <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // DMA fetch of segment words
    // ----------------------------------------------------------------
    vfdsc_pkg::vfdsc_fetch_e fst_q, next_fst;
    logic [4:0]  fidx_q, next_fidx;         // Slot being fetched
    vfdsc_pkg::vfdsc_word_s fw_q, next_fw;  // Word being built
    logic        next_req;
    logic [8:0]  next_addr;
    logic [3:0]  fdig;
    logic        fifo_ready;

    // Byte address of a fetch step, inside 1A0H..1FFH
    function automatic logic [8:0] fetch_addr(input vfdsc_pkg::vfdsc_fetch_e st,
                                              input logic [3:0] d);
        case (st)
            vfdsc_pkg::F_LO:  return `VFD_LO_BASE + {3'h0, d, 2'h0};
            vfdsc_pkg::F_MID: return `VFD_LO_BASE + {3'h0, d, 2'h2};
            vfdsc_pkg::F_UP:  return `VFD_UP_BASE + {4'h0, d, 1'b0};
            default:          return `VFD_LO_BASE;
        endcase
    endfunction : fetch_addr

    // Fetch sequence, stalled by a full buffer
    always_comb begin
        next_fst  = fst_q;
        next_fidx = fidx_q;
        next_fw   = fw_q;
        case (fst_q)
            vfdsc_pkg::F_IDLE: ;            // Wait for period start
            vfdsc_pkg::F_LO: begin
                if (DMA_GNT_I) begin
                    next_fw.lo = DMA_DATA_I;
                    next_fst   = vfdsc_pkg::F_MID;
                end
            end
            vfdsc_pkg::F_MID: begin
                if (DMA_GNT_I) begin
                    next_fw.mid = DMA_DATA_I;
                    next_fst    = vfdsc_pkg::F_UP;
                end
            end
            vfdsc_pkg::F_UP: begin
                if (DMA_GNT_I) begin
                    next_fw.up = DMA_DATA_I;
                    next_fst   = vfdsc_pkg::F_PUSH;
                end
            end
            vfdsc_pkg::F_PUSH: begin
                if (fifo_ready) begin       // Key slot word is the last
                    next_fidx = 5'(fidx_q + 5'h01);
                    next_fst  = (fidx_q == last_of(cfg_q.n)) ? vfdsc_pkg::F_IDLE
                                                              : vfdsc_pkg::F_LO;
                end
            end
            default: next_fst = vfdsc_pkg::F_IDLE;
        endcase
        if (start) begin                    // Restart with new period
            next_fst  = vfdsc_pkg::F_LO;
            next_fidx = 5'h00;
        end else if (stop) begin
            next_fst  = vfdsc_pkg::F_IDLE;
        end
        // Key slot reads the key buffers
        fdig = (next_fidx == last_of(next_cfg.n)) ? `VFD_KEY_DIGIT : next_fidx[3:0];
        next_req  = (next_fst == vfdsc_pkg::F_LO) | (next_fst == vfdsc_pkg::F_MID)
                  | (next_fst == vfdsc_pkg::F_UP);
        next_addr = fetch_addr(next_fst, fdig);
    end

    // Fetch registers
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            fst_q      <= vfdsc_pkg::F_IDLE;
            fidx_q     <= 5'h00;
            fw_q       <= '0;
            DMA_REQ_O  <= 1'b0;
            DMA_ADDR_O <= `VFD_LO_BASE;
        end else begin
            fst_q      <= next_fst;
            fidx_q     <= next_fidx;
            fw_q       <= next_fw;
            DMA_REQ_O  <= next_req;
            DMA_ADDR_O <= next_addr;
        end
    end

    // Word buffer, flushed at every period start or stop
    vfdsc_fifo #(
        .W ($bits(vfdsc_pkg::vfdsc_word_s)),
        .D (`VFD_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_n_i     (RESET_N_I),
        .flush_i     (restart),
        .in_valid_i  (fst_q == vfdsc_pkg::F_PUSH),
        .in_data_i   (fw_q),
        .in_ready_o  (fifo_ready),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_word),
        .out_ready_i (pop)
    );

    // ----------------------------------------------------------------
    // Pin multiplexing
    // ----------------------------------------------------------------
    vfdsc_pkg::vfdsc_cfg_s pin_cfg;  // Pin roles
    logic [23:0] dyn_seg, next_seg;
    logic [15:0] dyn_dig, next_dig;
    assign pin_cfg = running_q ? cfg_q : live_cfg;
    assign dyn_seg = (running_q & loaded_q) ? word_q : 24'h000000;

    // Segment pins: low pins dynamic below the count, upper pins dynamic unless static, else port data
    for (genvar i = 0; i < 24; i++) begin : g_seg
        if (i < 16) begin : g_low
            assign next_seg[i] = (5'(i) < `VFD_SEG_BASE + {2'h0, pin_cfg.segk})
                               ? dyn_seg[i] : PORT_SEG_I[i];
        end else begin : g_up
            assign next_seg[i] = pin_cfg.up_static
                               ? PORT_SEG_I[i] : dyn_seg[i];
        end
    end

    // Digit pins: strobe within N, else port data
    for (genvar j = 0; j < 16; j++) begin : g_dig
        assign dyn_dig[j]  = running_q & ~key_slot & loaded_q
                           & (slot_q == 5'(j)) & digit_on;
        assign next_dig[j] = (4'(j) <= pin_cfg.n) ? dyn_dig[j]
                                                  : PORT_DIG_I[j];
    end

    // Output registers
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            SEG_O <= 24'h000000;
            DIG_O <= 16'h0000;
        end else begin
            SEG_O <= next_seg;
            DIG_O <= next_dig;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    logic [15:0] per_q;   // Clocks since last key slot start
    logic        seen_q;  // One key slot start seen
    // Count restarts only when the period timing may change, not every period
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || stop || (start && (live_cfg != cfg_q))) begin
            per_q  <= 16'h0000;
            seen_q <= 1'b0;
        end else begin
            per_q  <= KEY_SCAN_IRQ_O ? 16'h0001 : 16'(per_q + 16'h0001);
            seen_q <= seen_q | KEY_SCAN_IRQ_O;
        end
    end

    sequence s_key_start;
        $rose(ksf_q) ##0 KEY_SCAN_IRQ_O;
    endsequence
    sequence s_pulse_end;
        ##1 !KEY_SCAN_IRQ_O;
    endsequence

    a_reset_mode: assert property (disable iff (1'b0)
        !RESET_N_I |=> (mode_q == 4'h0 && digit_count_select_q == 4'h8 && !running_q))
        else $error("registers not at reset values");
    a_irq_slot: assert property ($rose(ksf_q) |-> s_key_start)
        else $error("key slot start without interrupt");
    a_irq_pulse: assert property (KEY_SCAN_IRQ_O |-> ksf_q ##0 s_pulse_end)
        else $error("interrupt not a single pulse in key slot");
    a_period_len: assert property (KEY_SCAN_IRQ_O && seen_q && $stable(cfg_q) |->
        per_q == 16'((cfg_q.cyc_long ? `VFD_CYC_LONG_N : `VFD_CYC_SHORT_N)
                     * ({12'h000, cfg_q.n} + 16'h0002)))
        else $error("display period length wrong");
    a_cut_width: assert property ($rose(|dyn_dig) |-> pos16 == cut_of(cfg_q.cut))
        else $error("digit strobe not at cut width");
    a_key_segs: assert property (ksf_q && loaded_q |-> dyn_dig == 16'h0000
        && dyn_seg == word_q)
        else $error("key slot shows digits or wrong data");
    a_stop_scan: assert property (!mode_q[`VFD_EN_BIT] |=> !running_q && !DMA_REQ_O)
        else $error("scan not stopped");
    a_dma_hold: assert property (DMA_REQ_O && !DMA_GNT_I && !restart |=>
        DMA_REQ_O && $stable(DMA_ADDR_O))
        else $error("dma request dropped or moved");
    a_dma_area: assert property (DMA_REQ_O |-> DMA_ADDR_O >= `VFD_UP_BASE)
        else $error("dma outside display area");
    a_cfg_hold: assert property (running_q && !period_end |=> $stable(cfg_q))
        else $error("configuration changed inside a period");

endmodule : vfdsc_top

`default_nettype wire

// ==== rtl/vfdsc_map.svh ====
// Register map, field positions, reset values and timing counts
// Assumes a 4-bit data-memory style register port and a 9-bit DMA space
`ifndef VFDSC_MAP_SVH
`define VFDSC_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define VFD_ADDR_MODE   12'hF88
`define VFD_ADDR_DIM    12'hF89
`define VFD_ADDR_DIGIT  12'hF8A
`define VFD_ADDR_UPPER_SEGMENT_STATIC_SEL  12'hFD5

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define VFD_MODE_RST    4'h0
`define VFD_DIM_RST     4'h0
`define VFD_DIGIT_RST   4'h8
`define VFD_UPPER_SEGMENT_STATIC_SEL_RST   2'h0
`define VFD_EN_BIT      3
`define VFD_SEG_BASE    5'h09
`define VFD_UP_SEGS     8

// ----------------------------------------------------------------
// Display cycle lengths in main clock periods, less one and in full
// ----------------------------------------------------------------
`define VFD_CYC_SHORT   11'h3FF
`define VFD_CYC_LONG    11'h7FF
`define VFD_CYC_SHORT_N 16'h0400
`define VFD_CYC_LONG_N  16'h0800

// ----------------------------------------------------------------
// Display data area
// ----------------------------------------------------------------
`define VFD_LO_BASE     9'h1C0
`define VFD_UP_BASE     9'h1A0
`define VFD_KEY_DIGIT   4'hF
`define VFD_FIFO_DEPTH  16

`endif

// ==== rtl/vfdsc_pkg.sv ====
// Types shared by the display scan controller and its buffer
// Assumes the constants of vfdsc_map.svh
package vfdsc_pkg;

    // Segment word of one display slot
    typedef struct packed {
        logic [7:0] up;   // Segments 23..16
        logic [7:0] mid;  // Segments 15..8
        logic [7:0] lo;   // Segments 7..0
    } vfdsc_word_s;

    // Configuration taken at each display period start
    typedef struct packed {
        logic [2:0] segk;      // Segment count code
        logic [3:0] n;         // Digit select value
        logic       cyc_long;  // Long display cycle
        logic [2:0] cut;       // Cut width code
        logic       up_static; // Upper eight segments static
    } vfdsc_cfg_s;

    // DMA fetch states
    typedef enum logic [4:0] {
        F_IDLE = 5'h01,
        F_LO   = 5'h02,
        F_MID  = 5'h04,
        F_UP   = 5'h08,
        F_PUSH = 5'h10
    } vfdsc_fetch_e;

endpackage : vfdsc_pkg

// ==== rtl/vfdsc_fifo.sv ====
// Segment word buffer between DMA fetch and display timing
// Assumes one clock, synchronous active-low reset, depth a power of two
`timescale 1ns/1ps
`default_nettype none

module vfdsc_fifo #(
    parameter int W = 24,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         flush_i,
    // Fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // Drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];        // Word storage
    logic [AW-1:0] wp_q, next_wp;    // Write index
    logic [AW-1:0] rp_q, next_rp;    // Read index
    logic [AW:0]   cnt_q, next_cnt;  // Fill level
    logic          push, pop;

    // ----------------------------------------------------------------
    // Pointer and level update
    // ----------------------------------------------------------------
    always_comb begin
        in_ready_o  = cnt_q != (AW+1)'(D);
        out_valid_o = cnt_q != '0;
        out_data_o  = mem_q[rp_q];
        push        = in_valid_i & in_ready_o;
        pop         = out_valid_o & out_ready_i;
        next_wp     = push ? AW'(wp_q + 1'b1) : wp_q;
        next_rp     = pop ? AW'(rp_q + 1'b1) : rp_q;
        next_cnt    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin  // Drop all words
            next_wp  = '0;
            next_rp  = '0;
            next_cnt = '0;
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= next_wp;
            rp_q  <= next_rp;
            cnt_q <= next_cnt;
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

endmodule : vfdsc_fifo

`default_nettype wire

// ==== bench/vfdsc_mem_model.sv ====
// Display data memory model answering DMA reads of the scan controller
// Assumes request held until grant; drives on the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module vfdsc_mem_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // DMA read port
    input  wire logic       req_i,
    input  wire logic [8:0] addr_i,
    output logic            gnt_o,
    output logic      [7:0] data_o
);
    logic [1:0] wait_cnt; // Cycles left before next grant
    logic       slow;     // Alternates prompt and slow answers
    // ----------------------------------------
    // Answer process
    // ----------------------------------------
    always @(negedge clk_i) begin
        if (!rst_n_i) begin
            gnt_o <= 1'b0;
            data_o <= 8'h00;
            wait_cnt <= 2'h0;
            slow <= 1'b0;
        end else if (gnt_o) begin
            gnt_o <= 1'b0;      // One-cycle grant
            data_o <= ~data_o;  // Released bus shows no stale byte
        end else if (req_i && wait_cnt == 2'h0) begin
            gnt_o <= 1'b1;
            data_o <= addr_i[7:0] ^ 8'h5A;
            wait_cnt <= slow ? 2'h3 : 2'h0;
            slow <= ~slow;
        end else begin
            data_o <= ~data_o;
            if (req_i) wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule : vfdsc_mem_model
`default_nettype wire

// ==== bench/vfdsc_top_tb_top.sv ====
// Self-checking bench of the display scan controller
// Assumes memory model on the DMA port; port digit 15 and port segments held high
`timescale 1ns/1ps
`default_nettype none

module vfdsc_top_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [3:0] wdat = 4'h0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [3:0] rdat;
    logic req, gnt, irq;
    logic [8:0] dadr;
    logic [7:0] ddat;
    logic [23:0] seg;
    logic [15:0] dig;
    int n_errors = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    vfdsc_top i_vfdsc_top (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdat), .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdat),
        .DMA_REQ_O(req), .DMA_ADDR_O(dadr), .DMA_GNT_I(gnt), .DMA_DATA_I(ddat),
        .PORT_SEG_I(24'hFFFFFF), .PORT_DIG_I(16'h8000), .SEG_O(seg),
        .DIG_O(dig), .KEY_SCAN_IRQ_O(irq));
    vfdsc_mem_model i_vfdsc_mem_model (.clk_i(clk), .rst_n_i(rst_n),
        .req_i(req), .addr_i(dadr), .gnt_o(gnt), .data_o(ddat));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task wr(input logic [11:0] a, input logic [3:0] d);
        @(negedge clk);
        addr = a;
        wdat = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask : wr
    task rd(input logic [11:0] a, output logic [3:0] d);
        @(negedge clk);
        addr = a;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        d = rdat;
        @(negedge clk);
        d = d | rdat; // Data stands one cycle, zero otherwise
    endtask : rd
    // Cycles up to the next key scan pulse, digits seen, digit 0 width
    task period(output int len, output logic [15:0] acc, output int hi);
        len = 0;
        acc = 16'h0000;
        hi = 0;
        for (int i = 0; i < 40000; i++) begin
            @(negedge clk);
            len++;
            acc = acc | dig;
            if (dig[0]) hi++;
            if (irq) break;
        end
        if (!irq) begin
            n_errors++;
            $display("Error at %0t: no key scan pulse", $time);
            end_of_test();
        end
    endtask : period
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        logic [3:0] d;
        rd(12'hF88, d);
        chk(d, 0);
        rd(12'hF8A, d);
        chk(d, 0);
        wr(12'hF8B, 4'hF);
        rd(12'hF8B, d);
        chk(d, 0);
        chk(req, 0);
        chk(seg, 24'h00FE00);
        chk(dig, 16'h8000);
    endtask : t_reset
    task t_enable;
        wr(12'hF88, 4'hF);
        for (int i = 0; i < 8 && !req; i++) @(negedge clk);
        chk(req, 1);
        chk(dadr, 9'h1C0);
    endtask : t_enable
    task t_scan(input logic [3:0] n, input int cyc, input int cut,
                input logic [15:0] dexp);
        int len;
        int hi;
        logic [15:0] acc;
        logic [3:0] d;
        period(len, acc, hi);
        period(len, acc, hi);
        chk(24'(len), 24'(cyc * (n + 2)));
        chk(acc, dexp);
        chk(24'(hi >= cyc - cut - 2 && hi <= cyc - cut), 1);
        rd(12'hF8A, d);
        chk(d, {1'b1, n[2:0]});
        chk(seg, 24'hE4A4A6);
        chk(dig, 16'h8000);
    endtask : t_scan
    task t_stop;
        wr(12'hF88, 4'h0);
        repeat (4) @(negedge clk);
        chk(req, 0);
        chk(seg, 24'h00FE00);
        chk(dig, 16'h8000);
        wr(12'hFD5, 4'h1);
        @(negedge clk);
        chk(seg, 24'hFFFE00);
    endtask : t_stop
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_enable();
        t_scan(4'h8, 1024, 64, 16'h81FF);
        wr(12'hF8A, 4'h9);
        wr(12'hF89, 4'hF);
        t_scan(4'h9, 2048, 1792, 16'h83FF);
        t_stop();
        end_of_test();
    end
endmodule : vfdsc_top_tb_top
`default_nettype wire
